// file: core/ira_pkg.sv
`default_nettype none
package ira_pkg;
  localparam logic [6:0] IRA_DEV_ADDR = 7'h60;
  localparam int IRA_DATA_W = 8;
  localparam int IRA_SUB_W = 8;
  localparam logic [3:0] IRA_BIT_LAST = 4'h7;
  localparam logic [3:0] IRA_BIT_ACK = 4'h8;
  localparam logic [7:0] IRA_RD_RESET = 8'h00;
  localparam int IRA_SYNC_STAGES = 2;
endpackage : ira_pkg
`default_nettype wire

// file: core/ira_slave.sv
// Notes on behaviour
// - Bytes travel most significant bit first in both directions.
// - Received bits are sampled on the rising serial clock edge.
// - The device pulls the data line low for acknowledge between the 8th and 9th falling edges.
// - A read byte is eight bits from the device followed by the master's acknowledge bit.
// - Read data changes after falling edges and is sampled by the master on rising edges.
// - The master's acknowledge in a read is sampled on the ninth rising edge.
// - Only the first data byte after the sub-address is stored; extra bytes are dropped.
// - Each register is eight bits wide.
// - The interrupt output has a selectable active level and floats while radio power is off.
`default_nettype none
module ira_slave (
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic clk_sys,
  input wire logic reset,
  output logic [ira_pkg::IRA_SUB_W-1:0] wr_addr,
  output logic [ira_pkg::IRA_DATA_W-1:0] wr_data,
  output logic wr_strobe,
  output logic [ira_pkg::IRA_SUB_W-1:0] rd_addr,
  input wire logic [ira_pkg::IRA_DATA_W-1:0] rd_data,
  input wire logic irq_req,
  input wire logic irq_active_high,
  input wire logic radio_power_bit,
  output logic irq_out,
  output logic irq_oe
);
  import ira_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_DEVADDR, ST_SUBADDR, ST_DATA, ST_READ, ST_IGNORE} ira_state_e;

  // Link domain: scl is the clock; the master never stops mid-byte.
  ira_state_e state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] sub_q;
  logic [7:0] data_q;
  logic stored_q;
  logic wtog_q;
  logic start_tog_q;
  logic stop_tog_q;
  logic start_seen_q;
  logic stop_seen_q;
  logic ack_q;
  logic [7:0] tx_q;
  logic drive_q;
  logic out_q;

  // Start and stop detectors run on sda edges while scl high
  always_ff @(negedge sda_in or posedge reset) begin
    if (reset) begin
      start_tog_q <= 1'b0;
    end else if (scl) begin
      start_tog_q <= ~start_tog_q;
    end
  end
  always_ff @(posedge sda_in or posedge reset) begin
    if (reset) begin
      stop_tog_q <= 1'b0;
    end else if (scl) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  logic start_ack_q;
  logic stop_ack_q;
  wire start_pend = start_tog_q ^ start_ack_q;
  wire stop_pend = stop_tog_q ^ stop_ack_q;
  wire [7:0] byte_in = {shift_q[6:0], sda_in};
  wire addr_match = byte_in[7:1] == IRA_DEV_ADDR;
  wire byte_done = bit_q == IRA_BIT_LAST;

  // Receive path on rising edges
  always_ff @(posedge scl or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      sub_q <= 8'h00;
      data_q <= 8'h00;
      stored_q <= 1'b0;
      wtog_q <= 1'b0;
      ack_q <= 1'b0;
      start_ack_q <= 1'b0;
      stop_ack_q <= 1'b0;
    end else begin
      start_ack_q <= start_tog_q;
      stop_ack_q <= stop_tog_q;
      if (start_pend) begin
        state_q <= ST_DEVADDR;
        bit_q <= 4'h1;
        shift_q <= {7'h00, sda_in};
        ack_q <= 1'b0;
      end else if (stop_pend) begin
        state_q <= ST_IDLE;
        bit_q <= 4'h0;
      end else if (bit_q == IRA_BIT_ACK) begin
        bit_q <= 4'h0;
        if (state_q == ST_READ && sda_in) begin
          state_q <= ST_IGNORE;
        end
      end else begin
        shift_q <= byte_in;
        bit_q <= bit_q + 4'h1;
        ack_q <= 1'b0;
        if (byte_done) begin
          case (state_q)
            ST_DEVADDR: begin
              ack_q <= addr_match;
              if (!addr_match) begin
                state_q <= ST_IGNORE;
              end else if (byte_in[0]) begin
                state_q <= ST_READ;
              end else begin
                state_q <= ST_SUBADDR;
              end
            end
            ST_SUBADDR: begin
              sub_q <= byte_in;
              stored_q <= 1'b0;
              ack_q <= 1'b1;
              state_q <= ST_DATA;
            end
            ST_DATA: begin
              ack_q <= 1'b1;
              if (!stored_q) begin
                data_q <= byte_in;
                stored_q <= 1'b1;
                wtog_q <= ~wtog_q;
              end
            end
            default: begin
              ack_q <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Transmit and acknowledge drive change only on falling edges
  always_ff @(negedge scl or posedge reset) begin
    if (reset) begin
      drive_q <= 1'b0;
      out_q <= 1'b1;
      tx_q <= IRA_RD_RESET;
    end else begin
      drive_q <= 1'b0;
      out_q <= 1'b1;
      if (bit_q == IRA_BIT_ACK && ack_q) begin
        drive_q <= 1'b1;
        out_q <= 1'b0;
        tx_q <= rd_data;
      end else if (state_q == ST_READ && bit_q == 4'h0) begin
        drive_q <= ~tx_q[7];
        out_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b1};
      end else if (state_q == ST_READ && bit_q < IRA_BIT_ACK) begin
        // The last data bit is launched at the seventh fall, so no count is skipped here
        drive_q <= ~tx_q[7];
        out_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  // Open drain: only low is driven; scl is never driven
  assign sda_out = 1'b0;
  assign sda_oe = drive_q & ~out_q & ~stop_pend;
  assign rd_addr = sub_q;

  // Write strobe crosses into the system domain as a toggle; data held stable until next write
  logic wtog_s;
  logic wtog_prev_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic wr_strobe_q;
  ira_sync #(.WIDTH(1)) u_wsync (
    .clk(clk_sys),
    .reset(reset),
    .d(wtog_q),
    .q(wtog_s)
  );
  wire wr_evt = wtog_s ^ wtog_prev_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wtog_prev_q <= 1'b0;
      wr_strobe_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wtog_prev_q <= wtog_s;
      wr_strobe_q <= wr_evt;
      if (wr_evt) begin
        wr_addr_q <= sub_q;
        wr_data_q <= data_q;
      end
    end
  end
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;
  assign wr_strobe = wr_strobe_q;

  // Interrupt pin: polarity select, floats without radio power
  logic irq_q;
  logic oe_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      irq_q <= irq_req ~^ irq_active_high;
      oe_q <= radio_power_bit;
    end
  end
  assign irq_out = irq_q;
  assign irq_oe = oe_q;
endmodule : ira_slave
`default_nettype wire

// file: core/ira_sync.sv
`default_nettype none
module ira_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : ira_sync
`default_nettype wire

// file: verif/ira_master_model.sv
`default_nettype none
module ira_master_model (
  output logic scl,
  output logic m_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial scl = 1'b1;
  initial m_low = 1'b0;
  // Data only moves with scl low, so no false start or stop
  task automatic bit_x(input logic b, output logic r);
    m_low = !b;
    #40 scl = 1'b1;
    r = sda;
    #80 scl = 1'b0;
    #40;
  endtask : bit_x
  task automatic start();
    m_low = 1'b0;
    #40 scl = 1'b1;
    #40 m_low = 1'b1;
    #40 scl = 1'b0;
    #40;
  endtask : start
  task automatic stop();
    m_low = 1'b1;
    #40 scl = 1'b1;
    #40 m_low = 1'b0;
    #40;
  endtask : stop
  task automatic tx(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(b[i], ack);
    bit_x(1'b1, ack);
  endtask : tx
  task automatic rx(output logic [7:0] b);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d);
      b[i] = d;
    end
    bit_x(1'b1, d);
  endtask : rx
endmodule : ira_master_model
`default_nettype wire

// file: verif/ira_slave_sva.sv
`default_nettype none
module ira_slave_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic irq_req,
  input wire logic irq_active_high,
  input wire logic radio_power_bit,
  input wire logic irq_out,
  input wire logic irq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_pull_only: assert property (sda_out == 1'b0) else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl) else $error("sda moved, scl high");
  a_bit_stands: assert property ($rose(sda_oe) |-> sda_oe [*3]) else $error("bit too short");
  a_strobe_one: assert property (wr_strobe |=> !wr_strobe) else $error("long strobe");
  a_write_hold: assert property (wr_strobe |=> $stable(wr_data) && $stable(wr_addr)) else $error("data moved");
  a_irq_level: assert property (!reset |=> irq_out == ($past(irq_active_high) ? $past(irq_req) : !$past(irq_req)))
    else $error("irq level");
  a_irq_float: assert property (!reset |=> irq_oe == $past(radio_power_bit)) else $error("irq enable");
  a_rst_quiet: assert property ($fell(reset) |-> !sda_oe && !wr_strobe && !irq_oe) else $error("not quiet");
endmodule : ira_slave_sva
bind ira_slave ira_slave_sva chk_u (.clk_sys, .reset, .scl, .sda_out, .sda_oe, .wr_strobe, .wr_addr, .wr_data,
  .irq_req, .irq_active_high, .radio_power_bit, .irq_out, .irq_oe);
`default_nettype wire

// file: verif/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset = 1, irq_req = 0, irq_active_high = 0, radio_power_bit = 0, ak;
  logic [7:0] rd_data = 8'h00, rx;
  wire logic scl, m_low, sda_out, sda_oe, wr_strobe, irq_out, irq_oe;
  wire logic [7:0] wr_addr, wr_data, rd_addr;
  wire logic sda = !((sda_oe && !sda_out) || m_low);
  int err_count = 0, checked = 0, n_wr = 0, cyc = 0;
  initial forever #25 clk_sys = !clk_sys;
  ira_slave dut_u (.scl, .sda_in(sda), .sda_out, .sda_oe, .clk_sys, .reset, .wr_addr, .wr_data, .wr_strobe,
    .rd_addr, .rd_data, .irq_req, .irq_active_high, .radio_power_bit, .irq_out, .irq_oe);
  ira_master_model m_u (.scl, .m_low, .sda);
  always @(posedge clk_sys) begin
    rd_data <= rd_addr ^ 8'h5A;
    n_wr <= n_wr + int'(wr_strobe === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] b, input logic exp_nak);
    m_u.tx(b, ak);
    chk({7'h0, ak}, {7'h0, exp_nak});
  endtask : send
  task automatic t_write();
    m_u.start();
    send(8'hC0, 1'b0);
    send(8'h0B, 1'b0);
    send(8'hA5, 1'b0);
    send(8'h3C, 1'b0);
    m_u.stop();
    repeat (10) @(posedge clk_sys);
    chk(8'(n_wr), 8'h01);
    chk(wr_addr, 8'h0B);
    chk(wr_data, 8'hA5);
  endtask : t_write
  task automatic t_read();
    m_u.start();
    send(8'hC0, 1'b0);
    send(8'h1E, 1'b0);
    m_u.start();
    send(8'hC1, 1'b0);
    m_u.rx(rx);
    m_u.stop();
    chk(rx, 8'h1E ^ 8'h5A);
    m_u.start();
    send(8'hC0, 1'b0);
    send(8'h0D, 1'b0);
    m_u.stop();
    m_u.start();
    send(8'hC1, 1'b0);
    m_u.rx(rx);
    m_u.stop();
    chk(rx, 8'h0D ^ 8'h5A);
  endtask : t_read
  task automatic t_foreign();
    m_u.start();
    send(8'hA0, 1'b1);
    send(8'h0B, 1'b1);
    m_u.stop();
    repeat (10) @(posedge clk_sys);
    chk(8'(n_wr), 8'h01);
  endtask : t_foreign
  task automatic t_irq();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      irq_active_high <= i[0];
      radio_power_bit <= i[1];
      irq_req <= i[2];
      repeat (3) @(posedge clk_sys);
      chk({6'h0, irq_oe, irq_out}, {6'h0, i[1], i[2] == i[0]});
    end
  endtask : t_irq
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    #13;
    t_write();
    t_read();
    t_foreign();
    t_irq();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
